// *** src/kdh_pkg.sv ***
// kdh_pkg: constants and carrier types for the keypad/display host command block.
// assumes a single 50 MHz clock domain and a synchronous active-low reset.
package kdh_pkg;
    // ==================================================================
    // command opcodes, bits 7:5 of a command byte
    localparam logic [2:0] OP_MODE = 3'h0;
    localparam logic [2:0] OP_CLOCK = 3'h1;
    localparam logic [2:0] OP_RD_QUEUE = 3'h2;
    localparam logic [2:0] OP_RD_DISP = 3'h3;
    localparam logic [2:0] OP_WR_DISP = 3'h4;
    localparam logic [2:0] OP_INHIBIT = 3'h5;
    localparam logic [2:0] OP_CLEAR = 3'h6;
    localparam logic [2:0] OP_END_INT = 3'h7;
    // ==================================================================
    // field positions inside a command byte
    localparam int AI_BIT = 4;
    localparam int ERR_MODE_BIT = 4;
    localparam int CLR_DISP_BIT = 2;
    localparam int CLR_QUEUE_BIT = 1;
    localparam int CLR_ALL_BIT = 0;
    localparam int MASK_A_BIT = 3;
    localparam int MASK_B_BIT = 2;
    localparam int BLANK_A_BIT = 1;
    localparam int BLANK_B_BIT = 0;
    // ==================================================================
    // values after reset and limits
    localparam logic [1:0] DISP_FMT_RST = 2'h1;
    localparam logic [2:0] KBD_MODE_RST = 3'h0;
    localparam logic [4:0] PRESCALE_RST = 5'h1F;
    localparam logic [4:0] PRESCALE_MIN = 5'h02;
    localparam logic [7:0] FILL_ZERO = 8'h00;
    localparam logic [7:0] FILL_SPACE = 8'h20;
    localparam logic [7:0] FILL_ONES = 8'hFF;
    localparam logic [4:0] CHARS_DECODED = 5'h04;
    localparam logic [4:0] CHARS_8 = 5'h08;
    localparam logic [4:0] CHARS_16 = 5'h10;
    // ==================================================================
    // keyboard mode groups, keyboard_mode_field bits 2:1
    localparam logic [1:0] KM_2KEY = 2'h0;
    localparam logic [1:0] KM_NKEY = 2'h1;
    localparam logic [1:0] KM_SENSOR = 2'h2;
    localparam logic [1:0] KM_STROBED = 2'h3;
    // ==================================================================
    // host bus pins as sampled on clk
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic cmd_sel;
        logic [7:0] data;
    } kdh_host_t;
    // status word layout
    typedef struct packed {
        logic disp_busy;
        logic sense_err;
        logic overrun;
        logic underrun;
        logic full;
        logic [2:0] count;
    } kdh_status_t;
endpackage : kdh_pkg

// *** src/kdh_top.sv ***
// kdh_top: host command decode, mode registers, display RAM and queue/sensor RAM.
// assumes host pins and scan-side inputs are synchronous to clk; scan timing,
// debounce and display refresh sequencing live outside and use the ports below.
//
// Summary of operation
// RL1: in keyboard or strobed modes the 8-entry RAM is a first-in first-out queue.
// RL2: queue status keeps count, full, empty; empty reads or full writes flag errors.
// RL3: keyboard and strobed modes raise irq_line while the queue is not empty.
// RL4: sensor mode loads rows from the matrix and raises irq_line on any change.
// RL5: host writes commands with command_select high; latched on write strobe rising edge.
// RL6: display_format_field picks 8/16 characters, left/right entry; 16 left after reset.
// RL7: keyboard_mode_field picks 2-key, N-key, sensor, strobed; low bit decoded scan.
// RL8: decoded scan limits the display to 4 characters regardless of format.
// RL9: program-clock loads prescale_divisor 2..31; reset gives 31; clears leave it.
// RL10: read-queue selects queue RAM for reads; sensor mode also loads row and step.
// RL11: read-display sets shared display address, auto step, and display read source.
// RL12: write-display sets address and auto step but keeps the read source.
// RL13: inhibit/blank command loads nibble write masks and blanks; all zero after reset.
// RL14: clear fill code picks zeros, 20 hex or ones; also sets the blank code.
// RL15: display clear lasts a full scan, refuses display writes, sets status bit 7.
// RL16: queue clear empties the queue, drops irq_line, returns sensor row to 0.
// RL17: clear-everything does display and queue clear and restarts timing.
// RL18: sensor change blocks sensor writes until end-interrupt, which drops irq_line.
// RL19: in N-key mode end-interrupt with error bit set enters special error mode.
// RL20: status read with command_select high returns queue, error and busy status.
// RL21: data reads use selected source; trailing edge advances; queue always advances.
// RL22: data writes go to display RAM and advance on write end when auto step set.
// RL23: key characters are control, shift, 3-bit row, 3-bit column from msb down.
// RL24: overrun on entry into full queue, underrun on empty read, both in status.
// RL25: with chip_select_n high all strobes are ignored and the bus is not driven.
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module kdh_top #(
    parameter int DEPTH = 8,
    parameter int DISP_WORDS = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // host bus
    input wire kdh_pkg::kdh_host_t host,
    output logic [7:0] data_out,
    output logic data_oe_n,
    output logic irq_line,
    // scan side entries
    input wire logic key_strobe,
    input wire logic [2:0] key_row,
    input wire logic [2:0] key_col,
    input wire logic shift_in,
    input wire logic control_strobe_in,
    input wire logic strobe_entry,
    input wire logic [7:0] return_lines,
    input wire logic sensor_row_valid,
    input wire logic [2:0] sensor_row,
    input wire logic [7:0] sensor_data,
    input wire logic multi_key_err,
    // display refresh
    input wire logic [3:0] scan_addr,
    input wire logic disp_scan_end,
    output logic [3:0] disp_a_out,
    output logic [3:0] disp_b_out,
    // mode outputs to scan logic
    output logic [1:0] display_format_field,
    output logic [2:0] keyboard_mode_field,
    output logic [4:0] prescale_divisor,
    output logic decoded_scan,
    output logic [4:0] display_chars,
    output logic error_mode,
    output logic timing_restart
);
    localparam int AW = $clog2(DEPTH);
    localparam int DW = $clog2(DISP_WORDS);
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

    // ==================================================================
    // host strobe edges
    logic rd_cyc_q, rd_cd_q, wr_cyc_q, wr_cd_q;
    logic [7:0] wr_data_q;
    logic sel_rd, sel_wr, rd_end, wr_end, cmd_go, dwr_go, drd_go;
    logic [2:0] op;

    assign sel_rd = ~host.cs_n & ~host.rd_n; // RL25
    assign sel_wr = ~host.cs_n & ~host.wr_n; // RL25
    assign rd_end = rd_cyc_q & ~sel_rd;
    assign wr_end = wr_cyc_q & ~sel_wr;
    assign cmd_go = wr_end & wr_cd_q; // RL5
    assign dwr_go = wr_end & ~wr_cd_q;
    assign drd_go = rd_end & ~rd_cd_q;
    assign op = wr_data_q[7:5];

    // data keeps following the bus while the strobe is low, so the last value wins
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_cyc_q <= 1'b0;
            rd_cd_q <= 1'b0;
            wr_cyc_q <= 1'b0;
            wr_cd_q <= 1'b0;
            wr_data_q <= 8'h00;
        end else begin
            rd_cyc_q <= sel_rd;
            wr_cyc_q <= sel_wr;
            if (sel_rd) begin
                rd_cd_q <= host.cmd_sel;
            end
            if (sel_wr) begin
                wr_cd_q <= host.cmd_sel;
                wr_data_q <= host.data; // RL5
            end
        end
    end

    logic is_mode, is_clock, is_rdq, is_rdd, is_wrd, is_inh, is_clr, is_eoi;
    assign is_mode = cmd_go && op == kdh_pkg::OP_MODE;
    assign is_clock = cmd_go && op == kdh_pkg::OP_CLOCK;
    assign is_rdq = cmd_go && op == kdh_pkg::OP_RD_QUEUE;
    assign is_rdd = cmd_go && op == kdh_pkg::OP_RD_DISP;
    assign is_wrd = cmd_go && op == kdh_pkg::OP_WR_DISP;
    assign is_inh = cmd_go && op == kdh_pkg::OP_INHIBIT;
    assign is_clr = cmd_go && op == kdh_pkg::OP_CLEAR;
    assign is_eoi = cmd_go && op == kdh_pkg::OP_END_INT;

    logic clr_all, clr_disp, clr_queue;
    assign clr_all = is_clr & wr_data_q[kdh_pkg::CLR_ALL_BIT];
    assign clr_disp = is_clr & wr_data_q[kdh_pkg::CLR_DISP_BIT] | clr_all; // RL17
    assign clr_queue = is_clr & wr_data_q[kdh_pkg::CLR_QUEUE_BIT] | clr_all; // RL17

    // ==================================================================
    // mode registers
    logic [1:0] disp_fmt_q;
    logic [2:0] kbd_mode_q;
    logic [4:0] prescale_q;
    logic err_mode_q;
    logic sensor_mode, queue_mode;

    assign sensor_mode = kbd_mode_q[2:1] == kdh_pkg::KM_SENSOR; // RL7
    assign queue_mode = ~sensor_mode;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            disp_fmt_q <= kdh_pkg::DISP_FMT_RST; // RL6
            kbd_mode_q <= kdh_pkg::KBD_MODE_RST; // RL7
            err_mode_q <= 1'b0;
        end else if (is_mode) begin
            disp_fmt_q <= wr_data_q[4:3]; // RL6
            kbd_mode_q <= wr_data_q[2:0]; // RL7
            err_mode_q <= 1'b0;
        end else if (is_eoi && kbd_mode_q[2:1] == kdh_pkg::KM_NKEY && wr_data_q[kdh_pkg::ERR_MODE_BIT]) begin
            err_mode_q <= 1'b1; // RL19
        end
    end

    // divisors below the floor are raised to it rather than dropped
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prescale_q <= kdh_pkg::PRESCALE_RST; // RL9
        end else if (is_clock) begin
            prescale_q <= (wr_data_q[4:0] < kdh_pkg::PRESCALE_MIN) ? kdh_pkg::PRESCALE_MIN : wr_data_q[4:0]; // RL9
        end
    end

    // ==================================================================
    // display addressing, masks and clear
    logic src_disp_q, disp_ai_q, du_q;
    logic [DW-1:0] disp_addr_q, size_mask, addr_next;
    logic [1:0] mask_q, blank_q;
    logic [7:0] blank_code_q, fill_val;
    logic [7:0] disp_ram [DISP_WORDS];

    always_comb begin
        if (kbd_mode_q[0]) begin
            size_mask = DW'(kdh_pkg::CHARS_DECODED - 5'h01); // RL8
        end else if (disp_fmt_q[0]) begin
            size_mask = DW'(kdh_pkg::CHARS_16 - 5'h01); // RL6
        end else begin
            size_mask = DW'(kdh_pkg::CHARS_8 - 5'h01); // RL6
        end
    end
    assign addr_next = (disp_addr_q + DW'(1)) & size_mask;

    always_comb begin
        if (!wr_data_q[4]) begin
            fill_val = kdh_pkg::FILL_ZERO; // RL14
        end else if (!wr_data_q[3]) begin
            fill_val = kdh_pkg::FILL_SPACE; // RL14
        end else begin
            fill_val = kdh_pkg::FILL_ONES; // RL14
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            src_disp_q <= 1'b0;
            disp_ai_q <= 1'b0;
            disp_addr_q <= '0;
        end else if (is_rdd || is_wrd) begin
            src_disp_q <= is_rdd | src_disp_q; // RL11 RL12
            disp_ai_q <= wr_data_q[kdh_pkg::AI_BIT];
            disp_addr_q <= wr_data_q[DW-1:0]; // RL11
        end else begin
            if (is_rdq) begin
                src_disp_q <= 1'b0; // RL10
            end
            if ((dwr_go && !du_q || drd_go && src_disp_q) && disp_ai_q) begin
                disp_addr_q <= addr_next; // RL21 RL22
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mask_q <= 2'h0; // RL13
            blank_q <= 2'h0; // RL13
            blank_code_q <= kdh_pkg::FILL_ZERO;
        end else begin
            if (is_inh) begin
                mask_q <= {wr_data_q[kdh_pkg::MASK_A_BIT], wr_data_q[kdh_pkg::MASK_B_BIT]}; // RL13
                blank_q <= {wr_data_q[kdh_pkg::BLANK_A_BIT], wr_data_q[kdh_pkg::BLANK_B_BIT]}; // RL13
            end
            if (is_clr) begin
                blank_code_q <= fill_val; // RL14
            end
        end
    end

    // the fill is instant but the RAM stays locked until the scan ends
    always_ff @(posedge clk) begin
        if (!rstn) begin
            du_q <= 1'b0;
        end else if (clr_disp) begin
            du_q <= 1'b1; // RL15
        end else if (disp_scan_end) begin
            du_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (clr_disp) begin
            for (int i = 0; i < DISP_WORDS; i++) begin
                disp_ram[i] <= fill_val; // RL14 RL17
            end
        end else if (dwr_go && !du_q) begin
            if (!mask_q[1]) begin
                disp_ram[disp_addr_q][7:4] <= wr_data_q[7:4]; // RL13 RL22
            end
            if (!mask_q[0]) begin
                disp_ram[disp_addr_q][3:0] <= wr_data_q[3:0]; // RL13 RL22
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            disp_a_out <= 4'h0;
            disp_b_out <= 4'h0;
        end else begin
            disp_a_out <= blank_q[1] ? blank_code_q[7:4] : disp_ram[scan_addr[DW-1:0]][7:4]; // RL13
            disp_b_out <= blank_q[0] ? blank_code_q[3:0] : disp_ram[scan_addr[DW-1:0]][3:0]; // RL13
        end
    end

    // ==================================================================
    // queue / sensor RAM
    logic [7:0] q_ram [DEPTH];
    logic [AW-1:0] wr_ptr_q, rd_ptr_q, sens_row_q;
    logic [AW:0] count_q;
    logic sens_ai_q, ovr_q, unr_q, sim_err_q, sens_irq_q, sens_hold_q, irq_q;
    logic full, empty, push_req, pop_req, do_push, do_pop, sens_wr, sens_chg;

    assign full = count_q == FULL_COUNT; // RL2
    assign empty = count_q == '0; // RL2
    assign push_req = queue_mode & (~kbd_mode_q[2] & key_strobe & ~sim_err_q
        | kbd_mode_q[2:1] == kdh_pkg::KM_STROBED & strobe_entry);
    assign pop_req = drd_go & ~src_disp_q & queue_mode;
    assign do_pop = pop_req & ~empty & ~clr_queue; // RL21
    assign do_push = push_req & (~full | do_pop) & ~clr_queue; // RL1
    assign sens_wr = sensor_mode & sensor_row_valid & ~sens_hold_q; // RL18
    assign sens_chg = sens_wr && q_ram[sensor_row[AW-1:0]] != sensor_data; // RL4

    always_ff @(posedge clk) begin
        if (do_push) begin
            q_ram[wr_ptr_q] <= kbd_mode_q[2] ? return_lines
                : {control_strobe_in, shift_in, key_row, key_col}; // RL23
        end else if (sens_wr) begin
            q_ram[sensor_row[AW-1:0]] <= sensor_data; // RL4
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn || clr_queue) begin
            wr_ptr_q <= '0; // RL16
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_q <= wr_ptr_q + AW'(1); // RL1
            end
            if (do_pop) begin
                rd_ptr_q <= rd_ptr_q + AW'(1); // RL1
            end
            if (do_push && !do_pop) begin
                count_q <= count_q + (AW + 1)'(1); // RL2
            end else if (do_pop && !do_push) begin
                count_q <= count_q - (AW + 1)'(1); // RL2
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sens_row_q <= '0;
            sens_ai_q <= 1'b0;
        end else if (clr_queue) begin
            sens_row_q <= '0; // RL16
        end else if (is_rdq && sensor_mode) begin
            sens_row_q <= wr_data_q[AW-1:0]; // RL10
            sens_ai_q <= wr_data_q[kdh_pkg::AI_BIT]; // RL10
        end else if (drd_go && !src_disp_q && sensor_mode && sens_ai_q) begin
            sens_row_q <= sens_row_q + AW'(1); // RL10 RL21
        end
    end

    // a new event in the same cycle as its clear keeps the flag set
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ovr_q <= 1'b0;
            unr_q <= 1'b0;
            sim_err_q <= 1'b0;
        end else begin
            ovr_q <= push_req & full & ~do_pop | ovr_q & ~clr_queue; // RL2 RL24
            unr_q <= pop_req & empty | unr_q & ~clr_queue; // RL2 RL24
            sim_err_q <= err_mode_q & multi_key_err | sim_err_q & ~clr_queue; // RL19
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sens_irq_q <= 1'b0;
            sens_hold_q <= 1'b0;
        end else begin
            sens_irq_q <= sens_chg | sens_irq_q & ~(is_eoi | clr_queue | drd_go & ~src_disp_q & ~sens_ai_q); // RL4 RL18
            sens_hold_q <= sens_chg | sens_hold_q & ~(is_eoi | clr_queue); // RL18
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else if (sensor_mode) begin
            irq_q <= sens_irq_q; // RL4
        end else begin
            irq_q <= ~empty | sim_err_q; // RL3
        end
    end

    // ==================================================================
    // host read data and status
    kdh_pkg::kdh_status_t status;
    logic [7:0] rd_data_q;
    logic restart_q;

    assign status.disp_busy = du_q; // RL15
    assign status.sense_err = sensor_mode ? sens_irq_q : sim_err_q;
    assign status.overrun = ovr_q; // RL24
    assign status.underrun = unr_q; // RL24
    assign status.full = full;
    assign status.count = count_q[2:0];

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_data_q <= 8'h00;
        end else if (host.cmd_sel) begin
            rd_data_q <= status; // RL20
        end else if (src_disp_q) begin
            rd_data_q <= disp_ram[disp_addr_q]; // RL21
        end else begin
            rd_data_q <= q_ram[sensor_mode ? sens_row_q : rd_ptr_q]; // RL21
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            restart_q <= 1'b0;
        end else begin
            restart_q <= clr_all; // RL17
        end
    end

    assign data_out = rd_data_q;
    assign data_oe_n = ~sel_rd; // RL25
    assign irq_line = irq_q;
    assign display_format_field = disp_fmt_q;
    assign keyboard_mode_field = kbd_mode_q;
    assign prescale_divisor = prescale_q;
    assign decoded_scan = kbd_mode_q[0];
    assign display_chars = kbd_mode_q[0] ? kdh_pkg::CHARS_DECODED
        : (disp_fmt_q[0] ? kdh_pkg::CHARS_16 : kdh_pkg::CHARS_8); // RL8
    assign error_mode = err_mode_q;
    assign timing_restart = restart_q;

    // ==================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    queue_push_a: assert property (do_push && !do_pop |=> count_q == $past(count_q) + 1) // RL1
        else $error("queue count did not grow on entry");
    overrun_set_a: assert property (push_req && full && !do_pop && !clr_queue |=> ovr_q && count_q == FULL_COUNT) // RL24
        else $error("overrun missing on full queue");
    underrun_set_a: assert property (pop_req && empty |=> unr_q && rd_ptr_q == $past(rd_ptr_q)) // RL2
        else $error("underrun missing on empty read");
    irq_queue_a: assert property (queue_mode && !empty && $stable(kbd_mode_q) |=> irq_line) // RL3
        else $error("irq not raised for waiting character");
    sensor_irq_a: assert property (sens_chg && !is_eoi |=> sens_hold_q ##1 irq_line || !sensor_mode) // RL4
        else $error("sensor change did not raise irq");
    prescale_keep_a: assert property (is_clr |=> prescale_q == $past(prescale_q)) // RL9
        else $error("clear altered prescale divisor");
    clear_busy_a: assert property (clr_disp |=> du_q && status.disp_busy) // RL15
        else $error("display clear not busy");
    busy_write_a: assert property (du_q && dwr_go && !clr_disp |=> disp_ram[$past(disp_addr_q)] == $past(disp_ram[disp_addr_q])) // RL15
        else $error("display written during clear");
    queue_clear_a: assert property (clr_queue |=> empty && sens_row_q == '0 ##1 !irq_line || sensor_mode) // RL16
        else $error("queue clear incomplete");
    end_int_a: assert property (is_eoi && !sens_chg |=> !sens_hold_q && !sens_irq_q) // RL18
        else $error("end interrupt did not release sensor");
    cs_idle_a: assert property (host.cs_n |-> data_oe_n) // RL25
        else $error("bus driven while deselected");
    step_read_a: assert property (drd_go && src_disp_q && disp_ai_q && !is_rdd && !is_wrd |=> disp_addr_q == ($past(addr_next))) // RL21
        else $error("display address did not step");
endmodule : kdh_top
`default_nettype wire

// *** testbench/kdh_host_model.sv ***
// kdh_host_model: processor side of the parallel host bus.
// assumes the block's clock; every change lands right after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module kdh_host_model (
    // clock
    input wire logic clk,
    // bus
    output var kdh_pkg::kdh_host_t host,
    input wire logic [7:0] data_out
);
    initial host = '{1'b1, 1'b1, 1'b1, 1'b1, 8'hA5};
    // released data bus flips so a stale byte never looks valid
    task automatic wr(input logic cs_n, input logic sel, input logic [7:0] d);
        @(posedge clk);
        host <= '{cs_n, 1'b1, 1'b0, sel, d};
        @(posedge clk);
        host <= '{1'b1, 1'b1, 1'b1, 1'b1, ~d};
        repeat (2) @(posedge clk);
        #1;
    endtask : wr
    task automatic rd(input logic sel, output logic [7:0] d);
        @(posedge clk);
        host <= '{1'b0, 1'b0, 1'b1, sel, ~host.data};
        @(posedge clk);
        #1 d = data_out;
        @(posedge clk);
        host <= '{1'b1, 1'b1, 1'b1, 1'b1, ~host.data};
        repeat (2) @(posedge clk);
        #1;
    endtask : rd
endmodule : kdh_host_model
`default_nettype wire

// *** testbench/keypad_display_host_commands_test.sv ***
// keypad_display_host_commands_test: self-checking bench with a queue model.
// assumes kdh_top and kdh_host_model; multi_key_err held low and scan_addr fixed at 2.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module keypad_display_host_commands_test;
    logic clk, rstn, key_strobe, shift_in, control_strobe_in, strobe_entry, disp_scan_end, srv;
    logic [2:0] key_row, key_col, srow;
    logic [7:0] return_lines, data_out, d, e, sdat;
    logic [3:0] disp_a_out, disp_b_out;
    logic data_oe_n, irq_line, decoded_scan, error_mode, timing_restart;
    logic [1:0] fmt;
    logic [2:0] kmode;
    logic [4:0] presc, chars, p;
    logic [7:0] ex[6] = '{8'h20, 8'h20, 8'h31, 8'h32, 8'h33, 8'h2F};
    kdh_pkg::kdh_host_t host;
    logic [7:0] q[$];
    int error_cnt, comparisons, i, rs_cnt;
    kdh_host_model host_u (.clk(clk), .host(host), .data_out(data_out));
    kdh_top dut_u (.clk(clk), .rstn(rstn), .host(host), .data_out(data_out), .data_oe_n(data_oe_n),
        .irq_line(irq_line), .key_strobe(key_strobe), .key_row(key_row), .key_col(key_col),
        .shift_in(shift_in), .control_strobe_in(control_strobe_in), .strobe_entry(strobe_entry),
        .return_lines(return_lines), .sensor_row_valid(srv), .sensor_row(srow),
        .sensor_data(sdat), .multi_key_err(1'b0), .scan_addr(4'h2), .disp_scan_end(disp_scan_end),
        .disp_a_out(disp_a_out), .disp_b_out(disp_b_out), .display_format_field(fmt),
        .keyboard_mode_field(kmode), .prescale_divisor(presc), .decoded_scan(decoded_scan),
        .display_chars(chars), .error_mode(error_mode), .timing_restart(timing_restart));
    // ==========================================================
    // helpers
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    task automatic push(input logic strb);
        logic [7:0] c;
        c = 8'($urandom);
        @(posedge clk);
        {control_strobe_in, shift_in, key_row, key_col} <= c;
        return_lines <= c;
        key_strobe <= !strb;
        strobe_entry <= strb;
        @(posedge clk);
        key_strobe <= 1'b0;
        strobe_entry <= 1'b0;
        if (q.size() < 8)
            q.push_back(c);
        repeat (2) @(posedge clk);
        #1;
    endtask : push
    // f is busy, overrun, underrun
    task automatic chk_st(input logic [2:0] f);
        host_u.rd(1'b1, d);
        `CHK(d, {f[2], 1'b0, f[1:0], q.size() == 8, 3'(q.size())})
    endtask : chk_st
    task automatic scan_end();
        @(posedge clk);
        disp_scan_end <= 1'b1;
        @(posedge clk);
        disp_scan_end <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : scan_end
    task automatic sense(input logic [7:0] v);
        @(posedge clk);
        {srv, sdat} <= {1'b1, v};
        @(posedge clk);
        srv <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : sense
    // ==========================================================
    // clock, watchdog, tests
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (timing_restart)
            rs_cnt++;
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
    initial begin
        {rstn, key_strobe, shift_in, control_strobe_in, strobe_entry, disp_scan_end, srv} = 7'h00;
        {key_row, key_col, return_lines, sdat} = 22'h000000;
        void'($urandom(32'hf495));
        srow = 3'($urandom);
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        #1;
        `CHK({fmt, kmode, presc, chars, irq_line}, {2'h1, 3'h0, 5'h1F, 5'h10, 1'b0})
        for (i = 0; i < 32; i++) begin
            host_u.wr(1'b0, 1'b1, 8'(i));
            `CHK({chars, decoded_scan}, {i[0] ? 5'h04 : i[3] ? 5'h10 : 5'h08, i[0]})
            `CHK({fmt, kmode}, 5'(i))
        end
        host_u.wr(1'b1, 1'b1, 8'h08);
        `CHK({fmt, kmode}, 5'h1F)
        p = 5'($urandom_range(31, 2));
        host_u.wr(1'b0, 1'b1, {3'h1, p});
        host_u.wr(1'b0, 1'b1, 8'hC1);
        `CHK(presc, p)
        chk_st(3'b100);
        scan_end();
        for (i = 0; i < 2; i++) begin
            host_u.wr(1'b0, 1'b1, i ? 8'h0E : 8'h08);
            host_u.wr(1'b0, 1'b1, 8'h40);
            repeat (9) push(i[0]);
            `CHK(irq_line, 1'b1)
            chk_st(3'b010);
            while (q.size() > 0) begin
                e = q.pop_front();
                host_u.rd(1'b0, d);
                `CHK(d, e)
            end
            `CHK(irq_line, 1'b0)
            host_u.rd(1'b0, d);
            chk_st(3'b011);
            push(i[0]);
            host_u.wr(1'b0, 1'b1, 8'hC2);
            q.delete();
            `CHK(irq_line, 1'b0)
            chk_st(3'b000);
        end
        host_u.wr(1'b0, 1'b1, 8'hD4);
        chk_st(3'b100);
        host_u.wr(1'b0, 1'b1, 8'h90);
        host_u.wr(1'b0, 0, 8'h55);
        scan_end();
        chk_st(3'b000);
        host_u.wr(1'b0, 1'b1, 8'h92);
        for (i = 0; i < 3; i++)
            host_u.wr(1'b0, 1'b0, 8'(i + 8'h31));
        host_u.wr(1'b0, 1'b1, 8'hA8);
        host_u.wr(1'b0, 1'b0, 8'hFF);
        host_u.wr(1'b0, 1'b1, 8'hA0);
        push(1'b1);
        host_u.wr(1'b0, 1'b1, 8'h90);
        e = q.pop_front();
        host_u.rd(1'b0, d);
        `CHK(d, e)
        host_u.wr(1'b0, 1'b1, 8'h70);
        for (i = 0; i < 6; i++) begin
            host_u.rd(1'b0, d);
            `CHK(d, ex[i])
        end
        `CHK({disp_a_out, disp_b_out}, 8'h31)
        host_u.wr(1'b0, 1'b1, 8'hA2);
        `CHK({disp_a_out, disp_b_out}, 8'h21)
        host_u.wr(1'b0, 1'b1, 8'h02);
        host_u.wr(1'b0, 1'b1, 8'hF0);
        `CHK(error_mode, 1'b1)
        host_u.wr(1'b0, 1'b1, 8'h04);
        host_u.wr(1'b0, 1'b1, {5'h0A, srow});
        e = 8'($urandom);
        sense(e);
        host_u.wr(1'b0, 1'b1, 8'hE0);
        `CHK(irq_line, 1'b0)
        sense(~e);
        `CHK(irq_line, 1'b1)
        sense(e);
        host_u.rd(1'b0, d);
        `CHK(d, ~e)
        host_u.wr(1'b0, 1'b1, 8'hE0);
        `CHK(irq_line, 1'b0)
        `CHK(rs_cnt, 1)
        give_verdict();
    end
endmodule : keypad_display_host_commands_test
`default_nettype wire
